/* File: hdl/olmd_pkg.sv */
package olmd_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 50;
    localparam int T_WAKE_US = 1000;
    localparam int T_SLEEP_US = 1000;
    localparam int T_OL_STEP_US = 10;
    localparam int STEP_CYCLES = T_OL_STEP_US * CLK_MHZ;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h0_0001;
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

    // Register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam int CTRL_OD_BIT = 0;
    localparam int CTRL_HIZ_BIT = 1;
    localparam int CTRL_MASK_BIT = 2;
    localparam int CTRL_SERIAL_BIT = 3;
    localparam int CTRL_IF_LSB = 4;
    localparam int ST_FLAG_LSB = 0;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_FAULT_BIT = 5;
    localparam int ST_SLEEP_BIT = 6;
    localparam int ST_STATE_LSB = 8;

    // Synchronised input vector layout
    localparam int SYNC_W = 10;
    localparam int SY_SLEEP = 0;
    localparam int SY_UNDERVOLTAGE_LOCKOUT = 1;
    localparam int SY_OCP = 2;
    localparam int SY_TSD = 3;
    localparam int SY_HS = 4;
    localparam int SY_LSN = 6;
    localparam int SY_LSF = 8;

    typedef enum logic [1:0] {
        IF_4PIN = 2'b00,
        IF_2PIN = 2'b01,
        IF_PAR = 2'b10,
        IF_IND = 2'b11
    } olmd_if_e;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_WAKE = 3'b001,
        ST_FULL = 3'b010,
        ST_VM = 3'b011,
        ST_GND = 3'b100,
        ST_OPER = 3'b101,
        ST_SLPENT = 3'b110
    } olmd_state_e;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } olmd_sync_s;

    typedef struct packed {
        olmd_state_e state;
        logic wakeing;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] step;
        logic [1:0] fullRes;
        logic [1:0] vmRes;
        logic [3:0] flag;
        logic olFault;
        logic od;
        logic hizSel;
        logic mask;
        logic serial;
        olmd_if_e ifMode;
        logic [31:0] rdata;
        logic slverr;
    } olmd_s;
endpackage

/* File: hdl/olmd_sync_if.sv */
`timescale 1ns/1ns
interface olmd_sync_if;
    import olmd_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface

/* File: hdl/olmd_sync.sv */
`timescale 1ns/1ns
module olmd_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin vector in, synchronised vector out
    olmd_sync_if.sync_side pins
);
    import olmd_pkg::*;

    olmd_sync_s q;
    olmd_sync_s next_q;

    // Second stage alone reads the first
    always_comb begin
        next_q = q;
        next_q.stage1 = pins.raw;
        next_q.stage2 = q.stage1;
        if (!rst_n) begin
            next_q = '0;
            // Sleep pin idles awake, so leaving reset is not taken for a fall
            next_q.stage1[SY_SLEEP] = 1'b1;
            next_q.stage2[SY_SLEEP] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    assign pins.sync = q.stage2;
endmodule

/* File: hdl/olmd_core.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Open-load test runs at power-up and on every wake from sleep.
// RQ2: Serial variant starts the test whenever software sets the on-demand bit; the code drops sets made outside operating mode.
// RQ3: Pin variant keeps bridges running on open load and pulls fault low.
// RQ4: Serial variant: hi-z select 0 keeps bridge running, 1 makes it hi-z.
// RQ5: Serial variant: fault mask stops open load from pulling fault low.
// RQ6: Whole bridge open sets both flags; connected clears; half open sets one.
// RQ7: Hi-z scope: full bridge, both bridges in parallel, half in independent.
// RQ8: Full-bridge load is open only when high and far low comparators read 1.
// RQ9: Test finishes before the wake or power-on delay ends.
// RQ10: Open-load fault stays latched until reset or sleep.
// RQ11: Second bridge gets the same full-bridge test and decode.
// RQ12: Supply load: pull down, low comparator 0 means no open load.
// RQ13: Ground load: pull up, high comparator 0 no open, 1 open.
// RQ14: Test runs three states: full-bridge, supply load, ground load.
// RQ15: Sleep pin low disables internals and makes every output hi-z.
// RQ16: Sleep pin high enters operating mode without further command.
// RQ17: Host waits the wake delay before driving bridge inputs.
// RQ18: Fault pin pulls low briefly during power-up.
// RQ19: Sleep is entered only after the sleep-entry delay following the fall.
// RQ20: Undervoltage, overcurrent, open load, thermal faults enter fault mode.
// RQ21: Host stops the motor before requesting an on-demand test.
// RQ22: Serial variant bridge state on open load follows hi-z select.
// RQ23: On-demand bit clears itself when the test completes.
module olmd_core #(
    parameter int WAKE_CYCLES = olmd_pkg::T_WAKE_US * olmd_pkg::CLK_MHZ,
    parameter int SLEEP_CYCLES = olmd_pkg::T_SLEEP_US * olmd_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [olmd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins and fault sources
    input wire logic sleepControlPin,
    input wire logic undervoltageLockout,
    input wire logic overcurrentFault,
    input wire logic thermalShutdownFault,
    // Comparators, index 0 first bridge, index 1 second bridge
    input wire logic [1:0] out1HighSideComparator,
    input wire logic [1:0] out1LowSideComparator,
    input wire logic [1:0] out2LowSideComparator,
    // Open-drain fault indicator
    input wire logic faultIndicatorPinIn,
    output logic faultIndicatorPinOut,
    output logic faultIndicatorPinOe_n,
    // Output stage control
    output logic [1:0] pullUpEn,
    output logic [1:0] pullDownEn,
    output logic [3:0] halfBridgeHiz,
    output logic internalEn,
    output logic sleepMode,
    output logic [3:0] openLoadFlag
);
    import olmd_pkg::*;

    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);
    localparam olmd_s RESET_Q = '{
        state: ST_FULL,
        wakeing: 1'b1,
        ifMode: IF_4PIN,
        rdata: RDATA_ZERO,
        default: '0
    };

    olmd_s q;
    olmd_s next_q;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    olmd_sync_if syncBus();

    assign syncBus.raw = {out2LowSideComparator, out1LowSideComparator,
                          out1HighSideComparator, thermalShutdownFault,
                          overcurrentFault, undervoltageLockout, sleepControlPin};

    olmd_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pins(syncBus.sync_side)
    );

    logic sleepHi;
    logic undervoltage_lockout;
    logic hardFault;
    logic [1:0] hs;
    logic [1:0] lsNear;
    logic [1:0] lsFar;

    assign sleepHi = syncBus.sync[SY_SLEEP];
    assign undervoltage_lockout = syncBus.sync[SY_UNDERVOLTAGE_LOCKOUT];
    assign hardFault = syncBus.sync[SY_UNDERVOLTAGE_LOCKOUT] | syncBus.sync[SY_OCP]
                       | syncBus.sync[SY_TSD];
    assign hs = syncBus.sync[SY_HS+:2];
    assign lsNear = syncBus.sync[SY_LSN+:2];
    assign lsFar = syncBus.sync[SY_LSF+:2];

    ////////////////////////////////////////////////////////////////////
    // Derived status

    logic testing;
    logic asleep;
    logic olDrive;
    logic faultLow;
    logic hizEn;
    logic [3:0] scopeHiz;
    logic stepDone;

    // Current sources and busy flag per test state
    always_comb begin
        testing = 1'b0;
        pullUpEn = 2'h0;
        pullDownEn = 2'h0;
        case (q.state)
            ST_FULL: begin
                testing = 1'b1;
                pullUpEn = 2'h3; // RQ8 RQ14
            end
            ST_VM: begin
                testing = 1'b1;
                pullDownEn = 2'h3; // RQ12 RQ14
            end
            ST_GND: begin
                testing = 1'b1;
                pullUpEn = 2'h3; // RQ13 RQ14
            end
            default: begin
                testing = 1'b0;
            end
        endcase
    end
    assign asleep = (q.state == ST_SLEEP);
    assign stepDone = (q.step == STEP_LAST);
    // Mask gates only the pin and the status fault bit; the latch and flags still record the open load
    assign olDrive = q.olFault && !(q.serial && q.mask); // RQ5
    assign faultLow = !asleep && (olDrive // RQ3
                      || (testing && q.wakeing) // RQ18
                      || hardFault); // RQ20
    assign hizEn = q.serial && q.hizSel; // RQ4 RQ22

    always_comb begin
        scopeHiz = '0;
        case (q.ifMode)
            IF_4PIN, IF_2PIN: begin
                scopeHiz[1:0] = {2{|q.flag[1:0]}}; // RQ7
                scopeHiz[3:2] = {2{|q.flag[3:2]}}; // RQ7
            end
            IF_PAR: begin
                scopeHiz = {4{|q.flag}}; // RQ7
            end
            IF_IND: begin
                scopeHiz = q.flag; // RQ7
            end
            default: begin
                scopeHiz = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Per-bridge open-load decode

    logic [3:0] decodedFlag;

    for (genvar k = 0; k < 2; k++) begin : g_bridge
        logic fullOpen;
        logic nearOpen;
        logic nearFlag;

        assign fullOpen = q.fullRes[k]; // RQ8 RQ11
        // Independent mode: near half open only when both single-ended checks agree
        assign nearOpen = q.vmRes[k] && hs[k]; // RQ12 RQ13
        assign nearFlag = (q.ifMode == IF_IND) ? nearOpen : fullOpen; // RQ6 RQ7
        assign decodedFlag[2*k+:2] = {fullOpen, nearFlag}; // RQ6
    end

    ////////////////////////////////////////////////////////////////////
    // Register read mux

    logic [31:0] readWord;

    always_comb begin
        readWord = RDATA_ZERO;
        case (paddr)
            ADDR_CTRL: begin
                readWord[CTRL_OD_BIT] = q.od; // RQ23
                readWord[CTRL_HIZ_BIT] = q.hizSel;
                readWord[CTRL_MASK_BIT] = q.mask;
                readWord[CTRL_SERIAL_BIT] = q.serial;
                readWord[CTRL_IF_LSB+:2] = q.ifMode;
            end
            ADDR_STATUS: begin
                readWord[ST_FLAG_LSB+:4] = q.flag;
                readWord[ST_BUSY_BIT] = testing;
                readWord[ST_FAULT_BIT] = faultLow;
                readWord[ST_SLEEP_BIT] = asleep;
                readWord[ST_STATE_LSB+:3] = q.state;
            end
            default: begin
                readWord = RDATA_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    logic setup;
    logic access;
    logic mapped;
    logic odSet;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
    // Requests outside operating mode are dropped, not queued
    assign odSet = access && pwrite && (paddr == ADDR_CTRL)
                   && pwdata[CTRL_OD_BIT] && q.serial
                   && (q.state == ST_OPER); // RQ2

    always_comb begin
        next_q = q;
        // Wake and sleep-entry windows share one counter
        if (q.cnt != '1) begin
            next_q.cnt = q.cnt + CNT_ONE;
        end
        if (testing) begin
            next_q.step = q.step + CNT_ONE;
            if (stepDone) begin
                next_q.step = '0;
            end
        end
        case (q.state)
            ST_SLEEP: begin
                next_q.flag = '0; // RQ10
                next_q.olFault = 1'b0; // RQ10
                next_q.od = 1'b0;
                if (sleepHi) begin
                    next_q.state = ST_FULL; // RQ1 RQ16
                    next_q.wakeing = 1'b1;
                    next_q.cnt = '0;
                    next_q.step = '0;
                end
            end
            ST_FULL: begin
                if (stepDone) begin
                    next_q.fullRes = hs & lsFar; // RQ8 RQ11
                    next_q.state = ST_VM; // RQ14
                end
            end
            ST_VM: begin
                if (stepDone) begin
                    next_q.vmRes = lsNear; // RQ12
                    next_q.state = ST_GND; // RQ14
                end
            end
            ST_GND: begin
                if (stepDone) begin
                    next_q.flag = decodedFlag; // RQ6 RQ11
                    next_q.olFault = q.olFault || (|next_q.flag); // RQ10
                    next_q.od = odSet; // RQ23
                    next_q.state = q.wakeing ? ST_WAKE : ST_OPER; // RQ9
                end
            end
            ST_WAKE: begin
                if (q.cnt >= WAKE_LAST) begin
                    next_q.state = ST_OPER; // RQ16
                    next_q.wakeing = 1'b0;
                end
            end
            ST_OPER: begin
                if (q.od) begin
                    next_q.state = ST_FULL; // RQ2
                    next_q.step = '0;
                end
            end
            ST_SLPENT: begin
                if (sleepHi) begin
                    next_q.state = ST_FULL; // RQ1
                    next_q.wakeing = 1'b1;
                    next_q.cnt = '0;
                    next_q.step = '0;
                end else if (q.cnt >= SLEEP_LAST) begin
                    next_q.state = ST_SLEEP; // RQ19
                end
            end
            default: begin
                next_q.state = ST_SLEEP;
            end
        endcase
        // A fall of the sleep pin cuts any test in flight short
        if (!sleepHi && !asleep && q.state != ST_SLPENT) begin
            next_q.state = ST_SLPENT; // RQ19
            next_q.cnt = '0;
        end
        // Register writes, set of on-demand wins over completion
        if (access && pwrite && paddr == ADDR_CTRL) begin
            next_q.hizSel = pwdata[CTRL_HIZ_BIT];
            next_q.mask = pwdata[CTRL_MASK_BIT];
            next_q.serial = pwdata[CTRL_SERIAL_BIT];
            next_q.ifMode = olmd_if_e'(pwdata[CTRL_IF_LSB+:2]);
        end
        if (odSet) begin
            next_q.od = 1'b1; // RQ2
        end
        // Read data captured in the setup phase
        if (setup) begin
            next_q.slverr = !mapped;
            next_q.rdata = readWord;
        end
        if (!rst_n) begin
            next_q = RESET_Q; // RQ1
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = q.rdata;
    // Zero wait states: every access completes in its first cycle
    assign pready = access;
    assign pslverr = access && q.slverr;

    assign faultIndicatorPinOut = 1'b0;
    assign faultIndicatorPinOe_n = !faultLow; // RQ3 RQ10

    // Bridges keep running on open load unless hi-z is selected
    assign halfBridgeHiz = (asleep || testing || hardFault) ? 4'hF // RQ15 RQ20
                           : (hizEn ? scopeHiz : 4'h0); // RQ3 RQ4
    assign internalEn = !asleep && !undervoltage_lockout; // RQ15
    assign sleepMode = asleep; // RQ15
    assign openLoadFlag = q.flag;
endmodule

/* File: bench/olmd_props.sv */
`timescale 1ns/1ns
module olmd_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched ports
    input wire logic sleepControlPin,
    input wire logic [1:0] pullUpEn,
    input wire logic [1:0] pullDownEn,
    input wire logic [3:0] halfBridgeHiz,
    input wire logic internalEn,
    input wire logic sleepMode,
    input wire logic [3:0] openLoadFlag
);
    import olmd_pkg::*;
    logic [CNT_W-1:0] pdCnt;
    // Counts the cycles of the supply-load step
    always_ff @(posedge mclk) begin
        if (!rst_n || !(|pullDownEn)) begin
            pdCnt <= '0;
        end else begin
            pdCnt <= pdCnt + CNT_ONE;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sleep_hiz_a: assert property (sleepMode |-> halfBridgeHiz == 4'hF && !internalEn)
        else $error("outputs active in sleep");
    pull_excl_a: assert property (!(|pullUpEn && |pullDownEn))
        else $error("pull-up and pull-down together");
    test_hiz_a: assert property (|pullUpEn || |pullDownEn |-> halfBridgeHiz == 4'hF)
        else $error("bridge driven during test");
    vm_step_len_a: assert property ($fell(|pullDownEn) |-> pdCnt == CNT_W'(STEP_CYCLES))
        else $error("supply-load step length wrong");
    vm_after_full_a: assert property ($rose(|pullDownEn) |-> $past(|pullUpEn))
        else $error("supply-load step out of order");
    gnd_after_vm_a: assert property ($fell(|pullDownEn) && !sleepMode |-> |pullUpEn)
        else $error("ground-load step missing");
    flag_hold_a: assert property ($changed(openLoadFlag)
        |-> $past(|pullUpEn) || !$past(sleepControlPin, 2) || sleepMode)
        else $error("flags changed outside test end");
    sleep_delay_a: assert property ($fell(sleepControlPin) |-> !sleepMode [*8])
        else $error("sleep entered too early");
    wake_exit_a: assert property ($rose(sleepControlPin) && sleepMode |-> ##[1:4] !sleepMode)
        else $error("no wake from sleep");
    wake_test_a: assert property ($rose(sleepControlPin) && sleepMode |-> ##[2:6] |pullUpEn)
        else $error("no test on wake");
endmodule
bind olmd_core olmd_props u_olmd_props (
    .mclk(mclk), .rst_n(rst_n), .sleepControlPin(sleepControlPin), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .halfBridgeHiz(halfBridgeHiz), .internalEn(internalEn),
    .sleepMode(sleepMode), .openLoadFlag(openLoadFlag)
);

/* File: bench/olmd_host.sv */
`timescale 1ns/1ns
module olmd_host #(
    parameter int WAKE_CYCLES = 2000
) (
    // Clock
    input wire logic mclk,
    // Sleep control
    output logic sleepControlPin
);
    initial sleepControlPin = 1'b1;
    task automatic drop();
        sleepControlPin <= 1'b0;
    endtask
    // Bridge inputs stay off until the wake delay has run
    task automatic wake();
        sleepControlPin <= 1'b1;
        repeat (WAKE_CYCLES) @(posedge mclk);
    endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import olmd_pkg::*;
    localparam int WK = 2000;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, sleepPin, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] hs, ls1, ls2, pullUpEn, pullDownEn;
    logic fOut, fOe_n, fWire, internalEn, sleepMode;
    logic [3:0] hiz, flags;
    logic [2:0] hf;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Pull-up on the open-drain fault line
    assign fWire = fOe_n ? 1'b1 : fOut;
    olmd_core #(.WAKE_CYCLES(WK), .SLEEP_CYCLES(WK)) u_olmd_core (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepControlPin(sleepPin), .undervoltageLockout(hf[0]), .overcurrentFault(hf[1]),
        .thermalShutdownFault(hf[2]), .out1HighSideComparator(hs),
        .out1LowSideComparator(ls1), .out2LowSideComparator(ls2),
        .faultIndicatorPinIn(fWire), .faultIndicatorPinOut(fOut),
        .faultIndicatorPinOe_n(fOe_n), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
        .halfBridgeHiz(hiz), .internalEn(internalEn), .sleepMode(sleepMode),
        .openLoadFlag(flags)
    );
    olmd_host #(.WAKE_CYCLES(WK)) u_olmd_host (.mclk(mclk), .sleepControlPin(sleepPin));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic poll(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 3000; i++) begin
            apb(1'b0, a, 32'h0000_0000);
            if ((rd & m) === v) break;
        end
        check(rd & m, v, "poll");
    endtask
    task automatic wait_oper();
        poll(ADDR_STATUS, 32'h0000_0700, 32'h0000_0500);
    endtask
    task automatic check_out(input logic [3:0] f, input logic [3:0] z, input logic flt,
            input string msg);
        check(flags, f, msg);
        check(hiz, z, msg);
        check(fWire, flt, msg);
    endtask
    task automatic run_od(input logic [31:0] c, input logic [1:0] h, input logic [1:0] l1,
            input logic [1:0] l2, input logic [3:0] f, input logic [3:0] z, input logic flt);
        hs <= h;
        ls1 <= l1;
        ls2 <= l2;
        apb(1'b1, ADDR_CTRL, c);
        apb(1'b1, ADDR_CTRL, c | 32'h0000_0001);
        poll(ADDR_CTRL, 32'h0000_0001, 32'h0000_0000);
        check_out(f, z, flt, "on-demand result");
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_powerup();
        repeat (10) @(posedge mclk);
        check(fWire, 1'b0, "power-up fault pulse");
        wait_oper();
        check_out(4'h0, 4'h0, 1'b1, "connected loads");
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        check(rd, RDATA_ZERO, "ctrl reset");
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        check(err, 1'b1, "unmapped write");
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd, RDATA_ZERO, "unmapped read");
        $display("test powerup done");
    endtask
    task automatic t_pin_open();
        hs <= 2'b10;
        ls2 <= 2'b10;
        u_olmd_host.drop();
        repeat (10) @(posedge mclk);
        check(sleepMode, 1'b0, "sleep entry delay");
        repeat (WK) @(posedge mclk);
        check({sleepMode, internalEn, hiz, flags}, 32'h0000_02F0, "sleep outputs");
        u_olmd_host.wake();
        check(flags, 4'hC, "test ends within wake delay");
        wait_oper();
        check_out(4'hC, 4'h0, 1'b0, "second bridge open");
        repeat (100) @(posedge mclk);
        check(fWire, 1'b0, "fault held");
        $display("test pin open done");
    endtask
    task automatic t_serial();
        hs <= 2'b00;
        ls2 <= 2'b00;
        u_olmd_host.drop();
        repeat (WK + 10) @(posedge mclk);
        u_olmd_host.wake();
        wait_oper();
        check(fWire, 1'b1, "sleep clears fault");
        run_od(32'h0000_000E, 2'b01, 2'b00, 2'b01, 4'h3, 4'h3, 1'b1);
        run_od(32'h0000_002E, 2'b01, 2'b00, 2'b01, 4'h3, 4'hF, 1'b1);
        run_od(32'h0000_001A, 2'b11, 2'b00, 2'b11, 4'hF, 4'hF, 1'b0);
        run_od(32'h0000_0038, 2'b01, 2'b01, 2'b00, 4'h1, 4'h0, 1'b0);
        $display("test serial done");
    endtask
    task automatic t_hard();
        apb(1'b1, ADDR_CTRL, 32'h0000_000C);
        check_out(4'h1, 4'h0, 1'b1, "open load masked");
        hf <= 3'h2;
        repeat (3) @(posedge mclk);
        check_out(4'h1, 4'hF, 1'b0, "overcurrent");
        hf <= 3'h4;
        repeat (3) @(posedge mclk);
        check_out(4'h1, 4'hF, 1'b0, "thermal");
        check(internalEn, 1'b1, "thermal keeps internals");
        hf <= 3'h1;
        repeat (3) @(posedge mclk);
        check({internalEn, hiz, fWire}, 32'h0000_001E, "undervoltage");
        hf <= 3'h0;
        repeat (3) @(posedge mclk);
        check_out(4'h1, 4'h0, 1'b1, "faults recovered");
        $display("test hard faults done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        hs = 2'b00;
        ls1 = 2'b00;
        ls2 = 2'b00;
        hf = 3'h0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_powerup();
        t_pin_open();
        t_serial();
        t_hard();
        end_sim();
    end
endmodule
